// ===== hw/csd_map.svh
// Register offsets, field positions and reset values of the CPU slow-down block.
`ifndef CSD_MAP_SVH
`define CSD_MAP_SVH

`define CSD_ADDR_W 4
`define CSD_DATA_W 16

`define CSD_DIV_OFS 4'h0
`define CSD_GATE_OFS 4'h2

`define CSD_ROI_BIT 15
`define CSD_RATIO_HI 14
`define CSD_RATIO_LO 12
`define CSD_SLOW_BIT 11

`define CSD_DIV_RST 16'h0000
`define CSD_GATE_RST 16'h0000
`define CSD_RATIO_RST 3'h0

`define CSD_CNT_W 7

`endif

// ===== hw/csd_pkg.sv
// Types shared by the CPU slow-down and peripheral clock gating block.
`default_nettype none
package csd_pkg;

  typedef logic [2:0] csd_ratio_t;

  typedef enum logic [1:0] {
    CSD_SEL_NONE = 2'h0,
    CSD_SEL_DIV = 2'h1,
    CSD_SEL_GATE = 2'h3
  } csd_sel_e;

endpackage

`default_nettype wire

// ===== hw/csd_clock_ctrl.sv
// CPU slow-down divider and per-peripheral clock gating with register port.
//
// Local design decisions: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "csd_map.svh"

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// RULE1 - Setting bit 11 of the divider register starts CPU slow-down.
// RULE2 - Bits 14..12 pick one of eight ratios 1:1..1:128, reset 1:1.
// RULE3 - System clock unchanged; only CPU is divided, peripherals run full rate.
// RULE4 - CPU enable is derived from the same clock, so both stay synchronous.
// RULE5 - With bit 15 set, an interrupt returns the CPU to full speed.
// RULE6 - With bit 15 clear, interrupts leave slow-down state and ratio alone.
// RULE7 - CPU and peripheral rates differ only when slowed at 1:2 or slower.
// RULE8 - A set gate bit stops every clock enable to that peripheral.
// RULE9 - Disabled peripheral ignores writes; its read data is marked invalid.
// RULE10 - Peripheral runs only if its gate bit is clear and it is present.
// RULE11 - Gate bits reset cleared, so present peripherals start enabled.
// RULE12 - Setting a gate bit disables the peripheral one CPU cycle later.
// RULE13 - Clearing a gate bit enables the peripheral one CPU cycle later.
// RULE14 - Ratio code n divides the CPU clock by two to the power n.
// RULE15 - An interrupt return to full speed also clears the slow-down bit.
module csd_clock_ctrl #(
  parameter int NPERIPH = 8,
  parameter logic [NPERIPH-1:0] PRESENT = '1
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [`CSD_ADDR_W-1:0] addr,
  input wire logic [`CSD_DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [`CSD_DATA_W-1:0] rdata,
  input wire logic irq,
  output logic cpu_clock,
  output logic peripheral_clock,
  output logic [NPERIPH-1:0] periph_clk_en,
  input wire logic [NPERIPH-1:0] periph_wr_req,
  output logic [NPERIPH-1:0] periph_wr_gated,
  output logic [NPERIPH-1:0] periph_rd_valid
);

  ////////////////////////////////////////////////////////////////////////////////
  // Address decoding.

  function automatic csd_pkg::csd_sel_e decode(
    input logic [`CSD_ADDR_W-1:0] a
  );
    csd_pkg::csd_sel_e s;
    s = csd_pkg::CSD_SEL_NONE;
    if (a == `CSD_DIV_OFS) begin
      s = csd_pkg::CSD_SEL_DIV;
    end else if (a == `CSD_GATE_OFS) begin
      s = csd_pkg::CSD_SEL_GATE;
    end
    return s;
  endfunction

  csd_pkg::csd_sel_e sel;
  logic wr_div;
  logic wr_gate;

  assign sel = decode(addr);
  assign wr_div = wr && (sel == csd_pkg::CSD_SEL_DIV);
  assign wr_gate = wr && (sel == csd_pkg::CSD_SEL_GATE);

  ////////////////////////////////////////////////////////////////////////////////
  // Divider register and register read path.

  logic slow;
  logic interrupt_restores_full_speed;
  csd_pkg::csd_ratio_t ratio;
  logic [NPERIPH-1:0] gate_bits;
  logic next_slow;
  logic next_roi;
  csd_pkg::csd_ratio_t next_ratio;
  logic [NPERIPH-1:0] next_gate_bits;
  logic [`CSD_DATA_W-1:0] next_rdata;
  logic [`CSD_DATA_W-1:0] div_word;
  logic [`CSD_DATA_W-1:0] gate_word;
  logic irq_return;

  // RULE5 interrupt return.
  // RULE6 needs return bit.
  assign irq_return = irq && interrupt_restores_full_speed && slow;

  always_comb begin
    div_word = '0;
    div_word[`CSD_ROI_BIT] = interrupt_restores_full_speed;
    div_word[`CSD_RATIO_HI:`CSD_RATIO_LO] = ratio;
    div_word[`CSD_SLOW_BIT] = slow;
  end

  assign gate_word = `CSD_DATA_W'(gate_bits);

  always_comb begin
    next_slow = slow;
    next_roi = interrupt_restores_full_speed;
    next_ratio = ratio;
    next_gate_bits = gate_bits;
    next_rdata = '0;
    // RULE1 slow-down enable.
    if (wr_div) begin
      next_roi = wdata[`CSD_ROI_BIT];
      next_ratio = wdata[`CSD_RATIO_HI:`CSD_RATIO_LO];
      next_slow = wdata[`CSD_SLOW_BIT];
    end
    // RULE15 hardware clear wins.
    if (irq_return) begin
      next_slow = 1'b0;
    end
    if (wr_gate) begin
      next_gate_bits = wdata[NPERIPH-1:0];
    end
    if (rd) begin
      unique case (sel)
        csd_pkg::CSD_SEL_DIV: next_rdata = div_word;
        csd_pkg::CSD_SEL_GATE: next_rdata = gate_word;
        csd_pkg::CSD_SEL_NONE: next_rdata = '0;
      endcase
    end
  end

  // RULE2 reset ratio 1:1.
  // RULE11 gate bits reset clear.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      slow <= 1'(`CSD_DIV_RST >> `CSD_SLOW_BIT);
      interrupt_restores_full_speed <= 1'b0;
      ratio <= `CSD_RATIO_RST;
      gate_bits <= '0;
      rdata <= '0;
    end else begin
      slow <= next_slow;
      interrupt_restores_full_speed <= next_roi;
      ratio <= next_ratio;
      gate_bits <= next_gate_bits;
      rdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // CPU clock enable divider.

  logic [`CSD_CNT_W-1:0] cnt;
  logic [`CSD_CNT_W-1:0] next_cnt;
  logic [`CSD_CNT_W-1:0] lim;

  // RULE14 power-of-two limit.
  assign lim = `CSD_CNT_W'((8'h01 << ratio) - 8'h01);

  always_comb begin
    next_cnt = cnt + `CSD_CNT_W'(1);
    // A ratio change restarts the count so it never runs past the new limit.
    if (!slow || wr_div || irq_return || cnt == lim) begin
      next_cnt = '0;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

  // RULE4 same-clock enable.
  // RULE7 differs only when slowed.
  assign cpu_clock = (cnt == '0);
  // RULE3 peripherals undivided.
  assign peripheral_clock = 1'b1;

  ////////////////////////////////////////////////////////////////////////////////
  // Peripheral gating, applied on the next CPU cycle.

  logic [NPERIPH-1:0] gate_act;
  logic [NPERIPH-1:0] next_gate_act;

  // RULE12 disable one cycle later.
  // RULE13 enable one cycle later.
  always_comb begin
    next_gate_act = gate_act;
    if (cpu_clock) begin
      next_gate_act = gate_bits;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      gate_act <= '0;
    end else begin
      gate_act <= next_gate_act;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NPERIPH; gi++) begin : g_periph
      // RULE8 stop clock enable.
      // RULE10 present and ungated.
      assign periph_clk_en[gi] = PRESENT[gi] && !gate_act[gi];
      // RULE9 block access.
      assign periph_wr_gated[gi] = periph_wr_req[gi] && periph_clk_en[gi];
      assign periph_rd_valid[gi] = periph_clk_en[gi];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions and covers.

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  property p_full_speed;
    !slow |=> cpu_clock;
  endproperty
  a_full_speed: assert property (p_full_speed) // RULE7
    else $error("cpu enable missing at full speed");

  property p_periph_full;
    peripheral_clock;
  endproperty
  a_periph_full: assert property (p_periph_full) // RULE3
    else $error("peripheral clock was divided");

  property p_half_rate;
    slow && ratio == 3'h1 && cpu_clock && !wr_div && !irq_return
      |=> !cpu_clock ##1 cpu_clock;
  endproperty
  a_half_rate: assert property (p_half_rate) // RULE14
    else $error("ratio 1 did not give half rate");

  property p_div_read;
    rd && sel == csd_pkg::CSD_SEL_DIV |=> rdata == $past(div_word);
  endproperty
  a_div_read: assert property (p_div_read) // RULE2
    else $error("divider register read back wrong");

  property p_roi_return;
    irq && interrupt_restores_full_speed && slow |=> !slow ##1 cpu_clock;
  endproperty
  a_roi_return: assert property (p_roi_return) // RULE5
    else $error("interrupt did not restore full speed");

  property p_no_roi;
    irq && !interrupt_restores_full_speed && !wr_div |=> $stable(slow) && $stable(ratio);
  endproperty
  a_no_roi: assert property (p_no_roi) // RULE6
    else $error("interrupt changed slow-down without return bit");

  property p_gate_hold;
    !cpu_clock |=> $stable(gate_act);
  endproperty
  a_gate_hold: assert property (p_gate_hold) // RULE12
    else $error("gating changed between cpu cycles");

  property p_gate_take;
    cpu_clock |=> gate_act == $past(gate_bits);
  endproperty
  a_gate_take: assert property (p_gate_take) // RULE13
    else $error("gating not applied on cpu cycle");

  property p_wr_block;
    gate_act != '0 |-> (periph_wr_gated & gate_act) == '0;
  endproperty
  a_wr_block: assert property (p_wr_block) // RULE9
    else $error("write passed to disabled peripheral");

  property p_absent;
    (periph_clk_en & ~PRESENT) == '0;
  endproperty
  a_absent: assert property (p_absent) // RULE10
    else $error("absent peripheral was clocked");

  property p_slow_write;
    wr_div && !irq_return |=> slow == $past(wdata[`CSD_SLOW_BIT]);
  endproperty
  a_slow_write: assert property (p_slow_write) // RULE1
    else $error("slow-down enable not taken from write");

  property p_ratio_write;
    wr_div |=> ratio == $past(wdata[`CSD_RATIO_HI:`CSD_RATIO_LO]);
  endproperty
  a_ratio_write: assert property (p_ratio_write) // RULE2
    else $error("ratio field not taken from write");

  property p_cnt_limit;
    slow |-> cnt <= lim;
  endproperty
  a_cnt_limit: assert property (p_cnt_limit) // RULE14
    else $error("divider count beyond ratio limit");

  property p_gate_read;
    rd && sel == csd_pkg::CSD_SEL_GATE |=> rdata == $past(gate_word);
  endproperty
  a_gate_read: assert property (p_gate_read) // RULE11
    else $error("gate register read back wrong");

  c_slow_max: cover property (slow && ratio == 3'h7 && cpu_clock);
  c_roi: cover property (irq && interrupt_restores_full_speed && slow);
  c_gate: cover property (cpu_clock && gate_bits != gate_act);
  c_blocked: cover property (periph_wr_req != '0 && periph_wr_gated == '0);
  c_half_rate: cover property (slow && ratio == 3'h1 && cpu_clock);

endmodule // csd_clock_ctrl

`default_nettype wire

// ===== test/csd_far_model.sv
// Far-side model: peripherals that issue register writes on alternate cycles.
`timescale 1ns/10ps
`default_nettype none
module csd_far_model (
  input wire logic mclk,
  input wire logic nrst,
  output logic [7:0] periph_wr_req
);
  // A pattern that changes every cycle keeps a stale request from passing unseen.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      periph_wr_req <= 8'hA5;
    end else begin
      periph_wr_req <= ~periph_wr_req;
    end
  end
endmodule // csd_far_model
`default_nettype wire

// ===== test/tb_top.sv
// Self-checking bench for the CPU slow-down and clock gating block.
`timescale 1ns/10ps
`default_nettype none
`include "csd_map.svh"
module tb_top;
  logic mclk, nrst, wr, rd, irq;
  logic [3:0] addr;
  logic [15:0] wdata, rdata, v;
  logic cpu_clock, peripheral_clock;
  logic [7:0] en, req, gated, rdv;
  int fail_count, comparisons;
  csd_clock_ctrl #(.NPERIPH(8), .PRESENT(8'h7F)) dut (.mclk(mclk), .nrst(nrst),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq),
    .cpu_clock(cpu_clock), .peripheral_clock(peripheral_clock), .periph_clk_en(en),
    .periph_wr_req(req), .periph_wr_gated(gated), .periph_rd_valid(rdv));
  csd_far_model far (.mclk(mclk), .nrst(nrst), .periph_wr_req(req));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  // Counts CPU and peripheral enables over n settled cycles.
  task automatic count(input int n, output logic [15:0] nc, output logic [15:0] np);
    nc = 16'h0000;
    np = 16'h0000;
    repeat (n) begin
      nc += 16'(cpu_clock);
      np += 16'(peripheral_clock);
      @(posedge mclk);
      #1;
    end
  endtask
  task automatic pulse_irq;
    @(posedge mclk);
    irq <= 1'b1;
    @(posedge mclk);
    irq <= 1'b0;
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_ratio;
    logic [15:0] nc, np;
    for (int r = 0; r < 8; r++) begin
      wr_reg(`CSD_DIV_OFS, 16'h0800 | 16'(r << 12));
      count(256, nc, np);
      chk(nc, 16'h0100 >> r);
      chk(np, 16'h0100);
    end
  endtask
  task automatic t_irq;
    logic [15:0] nc, np;
    wr_reg(`CSD_DIV_OFS, 16'h2800);
    pulse_irq;
    rd_reg(`CSD_DIV_OFS, v);
    chk(v, 16'h2800);
    wr_reg(`CSD_DIV_OFS, 16'hA800);
    pulse_irq;
    count(8, nc, np);
    chk(nc, 16'h0008);
    rd_reg(`CSD_DIV_OFS, v);
    chk(v, 16'hA000);
  endtask
  task automatic t_gate;
    rd_reg(`CSD_GATE_OFS, v);
    chk(v, `CSD_GATE_RST);
    chk(en, 8'h7F);
    wr_reg(`CSD_GATE_OFS, 16'h0001);
    chk(en, 8'h7F);
    @(posedge mclk);
    #1;
    chk(en, 8'h7E);
    chk(rdv, 8'h7E);
    chk(gated, req & 8'h7E);
    wr_reg(`CSD_GATE_OFS, 16'h0080);
    chk(en, 8'h7E);
    @(posedge mclk);
    #1;
    chk(en, 8'h7F);
    chk(gated, req & 8'h7F);
    wr_reg(4'h6, 16'hFFFF);
    rd_reg(4'h6, v);
    chk(v, 16'h0000);
    rd_reg(`CSD_GATE_OFS, v);
    chk(v, 16'h0080);
    rd_reg(`CSD_DIV_OFS, v);
    chk(v, 16'hA000);
  endtask
  // Gating at ratio 1:4 lands only on the next CPU enable cycle.
  task automatic t_gate_slow;
    wr_reg(`CSD_DIV_OFS, 16'h2800);
    wr_reg(`CSD_GATE_OFS, 16'h0002);
    repeat (2) @(posedge mclk);
    #1;
    chk(en, 8'h7F);
    @(posedge mclk);
    #1;
    chk(en, 8'h7D);
    chk(gated, req & 8'h7D);
    wr_reg(`CSD_GATE_OFS, 16'h0000);
    @(posedge mclk);
    #1;
    chk(en, 8'h7D);
    @(posedge mclk);
    #1;
    chk(en, 8'h7F);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    nrst = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    irq = 1'b0;
    addr = 4'h0;
    wdata = 16'h0000;
    repeat (5) @(posedge mclk);
    #1;
    chk(rdata, 16'h0000);
    chk(cpu_clock, 1'b1);
    @(posedge mclk);
    nrst <= 1'b1;
    rd_reg(`CSD_DIV_OFS, v);
    chk(v, `CSD_DIV_RST);
    t_ratio;
    t_irq;
    t_gate;
    t_gate_slow;
    close_out;
  end
  initial begin
    #100000;
    fail_count++;
    close_out;
  end
endmodule // tb_top
`default_nettype wire
